// ==== rtl/rrs_regs.svh ====
// constants for the repeater reset and strap block
`ifndef RRS_REGS_SVH
`define RRS_REGS_SVH

// port count and counter memory geometry
`define RRS_NUM_PORTS    12
`define RRS_PORT_IDX_W   4
`define RRS_CNT_AW       8
`define RRS_CNT_DW       8
`define RRS_CNT_PORT_LSB 4
`define RRS_CNT_PORT_MSB 7

// reset pulse length monitor
`define RRS_CLK_MHZ      100
`define RRS_POR_MIN_US   150
`define RRS_RUN_MIN_US   4
`define RRS_RUN_MIN_CYC  (`RRS_RUN_MIN_US * `RRS_CLK_MHZ)
`define RRS_POR_MIN_CYC  (`RRS_POR_MIN_US * `RRS_CLK_MHZ)
`define RRS_RLEN_W       14

// reset values of held state
`define RRS_BUS_MODE_RST 1'h0
`define RRS_PORT_EN_RST  12'h000
`define RRS_POLARITY_RST 1'h1
`define RRS_REQ_N_RST    1'h1
`define RRS_RLEN_RST     14'h0000

`endif

// ==== rtl/rrs_pkg.sv ====
// types for the repeater reset and strap block
`include "rrs_regs.svh"

package rrs_pkg;

    // reset sequencing states
    typedef enum logic [1:0] {
        RRS_ST_POR   = 2'b00,
        RRS_ST_RESET = 2'b01,
        RRS_ST_RUN   = 2'b10
    } rrs_fsm_t;

    // whole state of the top module
    typedef struct packed {
        rrs_fsm_t                    fsm;
        logic                        in_reset;
        logic                        bus_mode;
        logic [`RRS_NUM_PORTS-1:0]   port_en;
        logic [`RRS_NUM_PORTS-1:0]   port_oe;
        logic                        polarity;
        logic                        req_n;
        logic                        jam_oe;
        logic [`RRS_RLEN_W-1:0]      rlen;
        logic                        short_rst;
        logic                        wr_refused;
    } rrs_state_t;

endpackage : rrs_pkg

// ==== rtl/rrs_cnt_mem.sv ====
// statistics and port attribute counter storage
`timescale 1ns/10ps
`include "rrs_regs.svh"

module rrs_cnt_mem (
    input  wire logic                    i_clk,
    input  wire logic                    i_we,
    input  wire logic [`RRS_CNT_AW-1:0]  i_addr,
    input  wire logic [`RRS_CNT_DW-1:0]  i_wdata,
    output logic      [`RRS_CNT_DW-1:0]  o_rdata
);

    logic [`RRS_CNT_DW-1:0] mem_q [0:(1<<`RRS_CNT_AW)-1];

    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    // no reset term: contents are random until software presets them
    always_ff @(posedge i_clk)
    begin
        if (i_we)
        begin
            mem_q[i_addr] <= i_wdata;
        end
        o_rdata <= mem_q[i_addr]; // read data from a register
    end

endmodule : rrs_cnt_mem

// ==== rtl/rrs_reset_strap.sv ====
// hardware reset, strap capture and counter preset gate of the repeater
//
// Operation
// - the block is in reset whenever the active-low reset pin is low and stays so while it is low.
// - while in reset every reset-affected control and status value is loaded with its default.
// - in reset outputs go idle, two-way pins are released, active-high low and active-low high.
// - the polarity indicator output is driven high during reset, an exception to the idle levels above.
// - reset leaves the statistics bank and the per-port attribute counter banks untouched.
// - the counters are not initialised at power-up and hold undefined values until written.
// - counter preset writes are taken only in software reset or for a port that is disabled.
// - bus mode and default port state are taken from the two straps while reset is asserted.
// - a bus mode strap of 1 selects asynchronous bus mode and 0 the synchronous legacy mode.
// - a port default strap of 1 enables all ports; 0 disables all and tri-states their drivers.
// - the port strap sets only the initial state; afterwards only software writes change ports.
`timescale 1ns/10ps
`include "rrs_regs.svh"

module rrs_reset_strap #(
    parameter logic [`RRS_RLEN_W-1:0] POR_MIN_CYC = `RRS_RLEN_W'(`RRS_POR_MIN_CYC)
) (
    input  wire logic                        i_clk,
    input  wire logic                        i_sys_rst,
    input  wire logic                        i_rst_n,
    input  wire logic                        i_bus_mode_strap,
    input  wire logic                        i_port_default_strap,
    input  wire logic                        i_sw_reset,
    input  wire logic                        i_port_en_wr,
    input  wire logic [`RRS_NUM_PORTS-1:0]   i_port_en_wdata,
    input  wire logic                        i_req_n_core,
    input  wire logic                        i_jam_oe_core,
    input  wire logic                        i_polarity_core,
    input  wire logic                        i_cnt_wr,
    input  wire logic [`RRS_CNT_AW-1:0]      i_cnt_addr,
    input  wire logic [`RRS_CNT_DW-1:0]      i_cnt_wdata,
    output logic                             o_in_reset,
    output logic                             o_async_bus_mode,
    output logic      [`RRS_NUM_PORTS-1:0]   o_port_enable,
    output logic      [`RRS_NUM_PORTS-1:0]   o_port_out_en,
    output logic                             o_polarity_indicator,
    output logic                             o_req_n,
    output logic                             o_jam_oe,
    output logic                             o_reset_short,
    output logic      [`RRS_CNT_DW-1:0]      o_cnt_rdata,
    output logic                             o_cnt_wr_refused
);

    // ---------------------------------------------------------------
    // constants and decoding
    // ---------------------------------------------------------------
    localparam logic [`RRS_RLEN_W-1:0]     RUN_MIN_CYC = `RRS_RLEN_W'(`RRS_RUN_MIN_CYC);
    localparam logic [`RRS_RLEN_W-1:0]     RLEN_MAX    = {`RRS_RLEN_W{1'b1}};
    localparam logic [`RRS_PORT_IDX_W-1:0] LAST_PORT   = `RRS_PORT_IDX_W'(`RRS_NUM_PORTS - 1);

    // a preset write is allowed in software reset, or when the addressed port is off
    function automatic logic cnt_write_ok(
        input logic [`RRS_CNT_AW-1:0]    addr,
        input logic [`RRS_NUM_PORTS-1:0] port_en,
        input logic                      sw_reset
    );
        logic [`RRS_PORT_IDX_W-1:0] port;
        port = addr[`RRS_CNT_PORT_MSB:`RRS_CNT_PORT_LSB];
        if (port <= LAST_PORT)
        begin
            cnt_write_ok = sw_reset || !port_en[port];
        end
        else
        begin
            cnt_write_ok = sw_reset; // shared bank has no port of its own
        end
    endfunction : cnt_write_ok

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    rrs_pkg::rrs_state_t        st_q;
    rrs_pkg::rrs_state_t        st_d;
    logic                       hw_reset;
    logic                       mem_we;
    logic [`RRS_NUM_PORTS-1:0]  port_oe_next;

    // pin is taken as synchronous to the clock
    assign hw_reset = !i_rst_n;

    // counter memory is written only outside hardware reset and when allowed
    assign mem_we = i_cnt_wr && !hw_reset
                    && cnt_write_ok(i_cnt_addr, st_q.port_en, i_sw_reset);

    // per-port driver enables follow the next enable state, off in reset;
    // built from the registered state and the write so no loop runs through st_d
    genvar g;
    generate
        for (g = 0; g < `RRS_NUM_PORTS; g = g + 1)
        begin : g_port_oe
            assign port_oe_next[g] = !hw_reset
                                     && (i_port_en_wr ? i_port_en_wdata[g]
                                                      : st_q.port_en[g]);
        end
    endgenerate

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.in_reset = hw_reset;
        st_d.wr_refused = i_cnt_wr && !mem_we;

        // straps are sampled while the pin is low and held afterwards
        if (hw_reset)
        begin
            st_d.bus_mode = i_bus_mode_strap;
            st_d.port_en  = {`RRS_NUM_PORTS{i_port_default_strap}};
        end
        else if (i_port_en_wr)
        begin
            st_d.port_en = i_port_en_wdata;
        end

        // req_n and jam_oe forced to their inactive level during reset, polarity forced high
        if (hw_reset)
        begin
            st_d.req_n    = `RRS_REQ_N_RST;
            st_d.jam_oe   = 1'b0;
            st_d.polarity = `RRS_POLARITY_RST;
        end
        else
        begin
            st_d.req_n    = i_req_n_core;
            st_d.jam_oe   = i_jam_oe_core;
            st_d.polarity = i_polarity_core;
        end

        // reset length monitor: first release checked against the power-up minimum
        case (st_q.fsm)
            rrs_pkg::RRS_ST_POR:
            begin
                if (hw_reset)
                begin
                    st_d.rlen = (st_q.rlen == RLEN_MAX) ? st_q.rlen
                                                        : `RRS_RLEN_W'(st_q.rlen + 1'b1);
                end
                else
                begin
                    st_d.fsm       = rrs_pkg::RRS_ST_RUN;
                    st_d.short_rst = (st_q.rlen < POR_MIN_CYC);
                end
            end
            rrs_pkg::RRS_ST_RESET:
            begin
                if (hw_reset)
                begin
                    st_d.rlen = (st_q.rlen == RLEN_MAX) ? st_q.rlen
                                                        : `RRS_RLEN_W'(st_q.rlen + 1'b1);
                end
                else
                begin
                    st_d.fsm       = rrs_pkg::RRS_ST_RUN;
                    st_d.short_rst = (st_q.rlen < RUN_MIN_CYC);
                end
            end
            rrs_pkg::RRS_ST_RUN:
            begin
                if (hw_reset)
                begin
                    st_d.fsm       = rrs_pkg::RRS_ST_RESET;
                    st_d.rlen      = `RRS_RLEN_W'(1);
                    st_d.short_rst = 1'b0;
                end
            end
            default:
            begin
                st_d.fsm = rrs_pkg::RRS_ST_POR;
            end
        endcase

        st_d.port_oe = port_oe_next;
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            st_q.fsm        <= rrs_pkg::RRS_ST_POR;
            st_q.in_reset   <= 1'b1;
            st_q.bus_mode   <= `RRS_BUS_MODE_RST;
            st_q.port_en    <= `RRS_PORT_EN_RST;
            st_q.port_oe    <= `RRS_PORT_EN_RST;
            st_q.polarity   <= `RRS_POLARITY_RST;
            st_q.req_n      <= `RRS_REQ_N_RST;
            st_q.jam_oe     <= 1'b0;
            st_q.rlen       <= `RRS_RLEN_RST;
            st_q.short_rst  <= 1'b0;
            st_q.wr_refused <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ---------------------------------------------------------------
    // counter storage
    // ---------------------------------------------------------------
    rrs_cnt_mem u_cnt_mem (
        .i_clk   (i_clk),
        .i_we    (mem_we),
        .i_addr  (i_cnt_addr),
        .i_wdata (i_cnt_wdata),
        .o_rdata (o_cnt_rdata)
    );

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign o_in_reset           = st_q.in_reset;
    assign o_async_bus_mode     = st_q.bus_mode;
    assign o_port_enable        = st_q.port_en;
    assign o_port_out_en        = st_q.port_oe;
    assign o_polarity_indicator = st_q.polarity;
    assign o_req_n              = st_q.req_n;
    assign o_jam_oe             = st_q.jam_oe;
    assign o_reset_short        = st_q.short_rst;
    assign o_cnt_wr_refused     = st_q.wr_refused;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    // reset flag tracks the pin one cycle later
    reset_follow_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        !i_rst_n [*2] |=> o_in_reset && $past(o_in_reset))
        else $error("in reset flag dropped while pin low");

    // reset flag clears one cycle after the pin is seen high
    release_follow_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        i_rst_n |=> !o_in_reset)
        else $error("in reset flag stuck after pin release");

    // inactive outputs during reset
    idle_outputs_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        !i_rst_n |=> o_req_n && !o_jam_oe && (o_port_out_en == '0))
        else $error("output active during reset");

    // polarity indicator high in reset
    polarity_high_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        !i_rst_n |=> o_polarity_indicator)
        else $error("polarity indicator not high in reset");

    // port defaults come from the strap
    port_default_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (!i_rst_n && !i_sys_rst)
        |=> o_port_enable == {`RRS_NUM_PORTS{$past(i_port_default_strap)}})
        else $error("port enables not loaded from strap");

    // bus mode taken from strap, held after release
    bus_mode_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        !i_rst_n ##1 i_rst_n [*3] |=> o_async_bus_mode == $past(i_bus_mode_strap, 4))
        else $error("bus mode does not hold the sampled strap");

    // strap changes outside reset have no effect
    strap_hold_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        i_rst_n |=> $stable(o_async_bus_mode))
        else $error("bus mode changed outside reset");

    // after reset only writes move the port enables
    port_sw_only_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_rst_n && !i_port_en_wr) |=> $stable(o_port_enable))
        else $error("port enables changed without a write");

    // a port write lands on the next cycle
    port_write_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_rst_n && i_port_en_wr) |=> o_port_enable == $past(i_port_en_wdata))
        else $error("port write not applied");

    // counters untouched by hardware reset
    cnt_keep_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        !i_rst_n |-> !mem_we)
        else $error("counter written during hardware reset");

    // preset writes refused unless allowed
    cnt_gate_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_cnt_wr && i_rst_n && !cnt_write_ok(i_cnt_addr, o_port_enable, i_sw_reset))
        |-> !mem_we ##1 o_cnt_wr_refused)
        else $error("disallowed counter preset not refused");

    // a late reset shorter than the minimum is flagged
    short_flag_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (st_q.fsm == rrs_pkg::RRS_ST_RESET && i_rst_n && st_q.rlen < RUN_MIN_CYC)
        |=> o_reset_short && !o_in_reset)
        else $error("short reset pulse not flagged");

endmodule : rrs_reset_strap

// ==== verif/rrs_reset_src.sv ====
// board reset source model driving the active-low reset pin
`timescale 1ns/10ps

module rrs_reset_src #(
    parameter logic [13:0] POR_CYC = 14'h001E
) (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_go,
    input  wire logic [13:0] i_len,
    output logic             o_rst_n
);
    logic [13:0] cnt_q = 14'h0000;

    // pin held low for i_len sampled edges; changes only just after an edge
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_rst_n <= 1'h0;
            cnt_q   <= POR_CYC;
        end
        else if (!o_rst_n)
        begin
            if (cnt_q <= 14'h0001)
                o_rst_n <= 1'h1;
            cnt_q <= cnt_q - 14'h0001;
        end
        else if (i_go)
        begin
            o_rst_n <= 1'h0;
            cnt_q   <= i_len;
        end
    end
endmodule : rrs_reset_src

// ==== verif/repeater_reset_strap_logic_bench.sv ====
// self-checking bench of the repeater reset and strap block
`timescale 1ns/10ps

module repeater_reset_strap_logic_bench;
    logic        i_clk = 1'h0;
    logic        i_sys_rst = 1'h1;
    logic        rst_n;
    logic        go = 1'h0;
    logic [13:0] len = 14'h0190;
    logic        bmode = 1'h1, pdef = 1'h1, sw_rst = 1'h0;
    logic        pwr = 1'h0, cwr = 1'h0;
    logic [11:0] pdat = 12'h0000;
    logic        req_c = 1'h0, jam_c = 1'h1, polar_c = 1'h0;
    logic [7:0]  caddr = 8'h00, cdat = 8'h00, crd;
    logic        in_rst, amode, polar, req_n, jam, short_f, refused;
    logic [11:0] pen, poe;
    int          err_total = 0;
    int          compares = 0;

    // ------------------------------------------------------------
    // clock, reset source and design
    // ------------------------------------------------------------
    initial forever #5 i_clk = ~i_clk;

    rrs_reset_src src_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_go(go),
                         .i_len(len), .o_rst_n(rst_n));

    rrs_reset_strap #(.POR_MIN_CYC(14'h0014)) dut_u (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_rst_n(rst_n),
        .i_bus_mode_strap(bmode), .i_port_default_strap(pdef),
        .i_sw_reset(sw_rst), .i_port_en_wr(pwr), .i_port_en_wdata(pdat),
        .i_req_n_core(req_c), .i_jam_oe_core(jam_c), .i_polarity_core(polar_c),
        .i_cnt_wr(cwr), .i_cnt_addr(caddr), .i_cnt_wdata(cdat),
        .o_in_reset(in_rst), .o_async_bus_mode(amode), .o_port_enable(pen),
        .o_port_out_en(poe), .o_polarity_indicator(polar), .o_req_n(req_n),
        .o_jam_oe(jam), .o_reset_short(short_f), .o_cnt_rdata(crd),
        .o_cnt_wr_refused(refused));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask : tick

    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        compares++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic report_and_stop();
        if (err_total == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    // bounded wait for the reset pin to reach a level
    task automatic wait_pin(input logic v);
        int k;
        k = 0;
        while (rst_n !== v && k < 2000)
        begin
            tick(1);
            #1;
            k++;
        end
        if (rst_n !== v)
        begin
            err_total++;
            $display("mismatch reset_pin expected %h seen %h", v, rst_n);
            report_and_stop();
        end
    endtask : wait_pin

    // ask the source for a low pulse of n edges
    task automatic pulse(input logic [13:0] n);
        tick(1);
        go  <= 1'h1;
        len <= n;
        tick(1);
        go  <= 1'h0;
        wait_pin(1'h0);
    endtask : pulse

    // wait for release and let the outputs settle
    task automatic release_pin();
        wait_pin(1'h1);
        tick(1);
        #1;
    endtask : release_pin

    // one counter preset write, then its refusal pulse
    task automatic cw(input logic [7:0] a, input logic [7:0] d, input logic s,
                      input logic r);
        tick(1);
        cwr    <= 1'h1;
        caddr  <= a;
        cdat   <= d;
        sw_rst <= s;
        tick(1);
        cwr <= 1'h0;
        #1;
        chk("cnt_refused", {11'h000, r}, {11'h000, refused});
        tick(1);
        #1;
        chk("cnt_refused_end", 12'h000, {11'h000, refused});
    endtask : cw

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        tick(1);
        caddr <= a;
        tick(2);
        #1;
        chk("cnt_rdata", {4'h0, e}, {4'h0, crd});
    endtask : rd

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic sc_power_up();
        release_pin();
        chk("in_reset", 12'h000, {11'h000, in_rst});
        chk("async_mode", 12'h001, {11'h000, amode});
        chk("port_en", 12'hFFF, pen);
        chk("port_oe", 12'hFFF, poe);
        chk("short", 12'h000, {11'h000, short_f});
        tick(1);
        bmode <= 1'h0;
        pdef  <= 1'h0;
        tick(3);
        #1;
        chk("async_held", 12'h001, {11'h000, amode});
        chk("port_held", 12'hFFF, pen);
    endtask : sc_power_up

    task automatic sc_short_pulse();
        pulse(14'h018F);
        release_pin();
        chk("short", 12'h001, {11'h000, short_f});
    endtask : sc_short_pulse

    task automatic sc_forced_outputs();
        pulse(14'h0190);
        tick(1);
        #1;
        chk("in_reset", 12'h001, {11'h000, in_rst});
        chk("req_n", 12'h001, {11'h000, req_n});
        chk("jam_oe", 12'h000, {11'h000, jam});
        chk("port_oe", 12'h000, poe);
        chk("polarity", 12'h001, {11'h000, polar});
        chk("short_clr", 12'h000, {11'h000, short_f});
        tick(1);
        pwr  <= 1'h1;
        pdat <= 12'hAAA;
        tick(1);
        pwr <= 1'h0;
        cw(8'h23, 8'h99, 1'h0, 1'h1);
        release_pin();
        chk("port_en", 12'h000, pen);
        chk("port_oe", 12'h000, poe);
        chk("async_mode", 12'h000, {11'h000, amode});
        chk("short", 12'h000, {11'h000, short_f});
        chk("req_n", 12'h000, {11'h000, req_n});
        chk("polarity", 12'h000, {11'h000, polar});
        chk("jam_oe", 12'h001, {11'h000, jam});
    endtask : sc_forced_outputs

    task automatic sc_port_write();
        tick(1);
        pwr  <= 1'h1;
        pdat <= 12'h00F;
        tick(1);
        pdat <= 12'h0F0;
        #1;
        chk("port_en", 12'h00F, pen);
        chk("port_oe", 12'h00F, poe);
        tick(1);
        pwr <= 1'h0;
        #1;
        chk("port_en", 12'h0F0, pen);
    endtask : sc_port_write

    task automatic sc_counter_gate();
        cw(8'h23, 8'h5A, 1'h0, 1'h0);
        rd(8'h23, 8'h5A);
        cw(8'h43, 8'h11, 1'h0, 1'h1);
        cw(8'h43, 8'h77, 1'h1, 1'h0);
        cw(8'hC0, 8'h3C, 1'h1, 1'h0);
        cw(8'hC1, 8'h01, 1'h0, 1'h1);
        rd(8'h43, 8'h77);
        rd(8'hC0, 8'h3C);
    endtask : sc_counter_gate

    task automatic sc_counters_kept();
        pulse(14'h0190);
        release_pin();
        rd(8'h23, 8'h5A);
        rd(8'hC0, 8'h3C);
    endtask : sc_counters_kept

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        tick(4);
        i_sys_rst <= 1'h0;
        sc_power_up();
        sc_short_pulse();
        sc_forced_outputs();
        sc_port_write();
        sc_counter_gate();
        sc_counters_kept();
        report_and_stop();
    end
endmodule : repeater_reset_strap_logic_bench
